// ---- sllc_pkg.sv ----
/*
  sllc_pkg: constants for the status lamp and local loop control block.
  assumes a 10 MHz system clock; all timing derived from it.
*/
package sllc_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PERIOD_MS       = 1000;
  localparam int unsigned HALF_MS         = 500;
  localparam int unsigned FLASH_MS        = 125;
  localparam int unsigned SEC_CYCLES      = (CLK_HZ / 1000) * PERIOD_MS;
  localparam int unsigned HALF_CYCLES     = (CLK_HZ / 1000) * HALF_MS;
  localparam int unsigned FLASH_CYCLES    = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned CLOSS_ZEROS     = 255;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam int unsigned TB_W            = 24;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  localparam int unsigned CTRL_LOCAL_LOOP  = 0;
  localparam int unsigned CTRL_UNFRAMED    = 1;
  localparam int unsigned CTRL_ERR_INSERT  = 2;
  localparam int unsigned CTRL_PAT_SEND    = 3;
  localparam int unsigned CTRL_REMOTE_LOOP = 4;
  localparam int unsigned CTRL_LOOP_REQ    = 5;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
endpackage

// ---- sllc_fifo.sv ----
/*
  sllc_fifo: holds no logic; the valid/ready queue is defined in sllc_top.sv
  so that one file carries the whole block.
  assumes sllc_top.sv is always compiled together with the package.
*/

// ---- sllc_top.sv ----
/*
  sllc_top: front-panel lamp drive and local loopback for a serial-to-E1
  converter.
  assumes line state inputs come from the framer on the same clock, the
  DTE leads and data arrive from pins and are synchronised here.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Function
// R1: transmit lamp on for one, off zero
// R2: transmit lamp only in active timeslots
// R3: receive lamp on for one, off zero
// R4: receive lamp forced off inactive timeslots
// R5: sync lamp on loss of sync
// R6: unframed: sync lamp shows transmit clock
// R7: alarm lamp blinks every half second
// R8: fault lamp on line or pattern errors
// R9: fault lamp lit while pattern mismatches
// R10: error insertion alone blinks fault once/second
// R11: local loop: test lamp brief on flashes
// R12: remote loop: test lamp brief off flashes
// R13: test lamp steady on pattern or loop request
// R14: local loop echoes DTE data unchanged
// R15: local loop from control bit or lead
// R16: carrier loss after 255 zeros, pulse clears
// R17: brief flash is one eighth second
module sllc_top #(
  parameter int unsigned SEC_CYC   = sllc_pkg::SEC_CYCLES,
  parameter int unsigned HALF_CYC  = sllc_pkg::HALF_CYCLES,
  parameter int unsigned FLASH_CYC = sllc_pkg::FLASH_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       line_tx_bit_i,
  input  wire logic       line_rx_bit_i,
  input  wire logic       bit_strobe_i,
  input  wire logic       slot_active_i,
  input  wire logic       sync_lost_i,
  input  wire logic       tx_clock_ok_i,
  input  wire logic       ais_i,
  input  wire logic       rai_i,
  input  wire logic       oof_i,
  input  wire logic       frame_err_i,
  input  wire logic       excess_zero_i,
  input  wire logic       slip_i,
  input  wire logic       severe_err_i,
  input  wire logic       pattern_err_i,
  input  wire logic       dte_local_loop_i,
  input  wire logic       dte_data_i,
  input  wire logic       dte_bit_strobe_i,
  input  wire logic       net_tx_ready_i,
  output logic            dte_rx_data_o,
  output logic            dte_rx_strobe_o,
  output logic            net_tx_data_o,
  output logic            net_tx_valid_o,
  output logic            tx_data_lamp_o,
  output logic            rx_data_lamp_o,
  output logic            sync_fail_lamp_o,
  output logic            alarm_lamp_o,
  output logic            fault_lamp_o,
  output logic            test_mode_lamp_o,
  output logic            power_lamp_o,
  output logic            carrier_loss_flag_o
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  rdata;
    logic [2:0]  ll_sync;
    logic        ll_lead;
    logic [2:0]  dd_sync;
    logic [2:0]  ds_sync;
    logic        ds_prev;
    logic [sllc_pkg::TB_W-1:0] tb;
    logic [7:0]  zero_cnt;
    logic        closs;
    logic        txl;
    logic        rxl;
    logic        syl;
    logic        all;
    logic        fll;
    logic        tml;
    logic        power_lamp;
    logic        echo_d;
    logic        echo_s;
  } sllc_st_s;

  sllc_st_s st_r;
  sllc_st_s st_nxt;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic dte_take;
  logic local_loop;
  logic flash;
  logic sec_wrap;
  logic alarm_cond;
  logic fault_cond;

  assign local_loop = st_r.ctrl[sllc_pkg::CTRL_LOCAL_LOOP] || st_r.ll_lead; // R15
  assign flash      = (st_r.tb < sllc_pkg::TB_W'(FLASH_CYC)); // R17
  assign sec_wrap   = (st_r.tb == sllc_pkg::TB_W'(SEC_CYC - 1));
  assign alarm_cond = ais_i || rai_i || oof_i || sync_lost_i;
  assign fault_cond = frame_err_i || excess_zero_i || slip_i || severe_err_i
                    || (st_r.ctrl[sllc_pkg::CTRL_PAT_SEND] && pattern_err_i);
  // sampled DTE bit, taken on the agreed strobe edge
  assign dte_take   = (st_r.ds_sync[1] == st_r.ds_sync[2]) && st_r.ds_sync[2]
                    && !st_r.ds_prev;

  // dte bits queue here on the way to the line; drain stalls on net_tx_ready_i
  sllc_fifo #(
    .WIDTH (1),
    .DEPTH (sllc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (enable_i),
    .in_valid_i  (dte_take && !local_loop),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (st_r.dd_sync[2]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (net_tx_ready_i),
    .out_data_o  (fifo_out_data)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.power_lamp = 1'b1;
    st_nxt.ll_sync = {st_r.ll_sync[1:0], dte_local_loop_i};
    if (st_r.ll_sync[1] == st_r.ll_sync[2]) begin
      st_nxt.ll_lead = st_r.ll_sync[2];
    end
    st_nxt.dd_sync = {st_r.dd_sync[1:0], dte_data_i};
    st_nxt.ds_sync = {st_r.ds_sync[1:0], dte_bit_strobe_i};
    if (st_r.ds_sync[1] == st_r.ds_sync[2]) begin
      st_nxt.ds_prev = st_r.ds_sync[2];
    end
    // register port
    st_nxt.rdata = 8'h00;
    if (reg_write_i) begin
      if (reg_addr_i == sllc_pkg::ADDR_CTRL) begin
        st_nxt.ctrl = reg_wdata_i;
      end
    end
    if (reg_read_i) begin
      if (reg_addr_i == sllc_pkg::ADDR_CTRL) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (reg_addr_i == sllc_pkg::ADDR_STATUS) begin
        st_nxt.rdata = {1'b0, fifo_in_ready, local_loop, st_r.closs,
                        st_r.fll, st_r.all, st_r.syl, st_r.tml};
      end
    end
    // timebase, one second period
    st_nxt.tb = sec_wrap ? '0 : st_r.tb + 1'b1;
    // data lamps follow each line bit inside active slots only
    if (bit_strobe_i) begin
      st_nxt.txl = slot_active_i && line_tx_bit_i; // R1 R2
      st_nxt.rxl = slot_active_i && line_rx_bit_i; // R3 R4
      if (line_rx_bit_i) begin
        st_nxt.zero_cnt = 8'h00;
        st_nxt.closs    = 1'b0; // R16
      end else if (st_r.zero_cnt != 8'(sllc_pkg::CLOSS_ZEROS)) begin
        st_nxt.zero_cnt = st_r.zero_cnt + 1'b1;
      end
      if (!line_rx_bit_i && st_r.zero_cnt == 8'(sllc_pkg::CLOSS_ZEROS - 1)) begin
        st_nxt.closs = 1'b1; // R16
      end
    end
    if (st_r.ctrl[sllc_pkg::CTRL_UNFRAMED]) begin
      st_nxt.syl = !tx_clock_ok_i; // R6
    end else begin
      st_nxt.syl = sync_lost_i; // R5
    end
    st_nxt.all = alarm_cond && flash; // R7
    if (alarm_cond && (st_r.tb >= sllc_pkg::TB_W'(HALF_CYC))
        && (st_r.tb < sllc_pkg::TB_W'(HALF_CYC + FLASH_CYC))) begin
      st_nxt.all = 1'b1; // R7
    end
    if (fault_cond) begin
      st_nxt.fll = 1'b1; // R8 R9
    end else if (st_r.ctrl[sllc_pkg::CTRL_ERR_INSERT]) begin
      st_nxt.fll = flash; // R10
    end else begin
      st_nxt.fll = 1'b0; // R9
    end
    // steady beats remote, remote beats local
    if (st_r.ctrl[sllc_pkg::CTRL_PAT_SEND] || st_r.ctrl[sllc_pkg::CTRL_LOOP_REQ]) begin
      st_nxt.tml = 1'b1; // R13
    end else if (st_r.ctrl[sllc_pkg::CTRL_REMOTE_LOOP]) begin
      st_nxt.tml = !flash; // R12
    end else if (local_loop) begin
      st_nxt.tml = flash; // R11
    end else begin
      st_nxt.tml = 1'b0;
    end
    // echo path: loopback returns the bit unchanged with its strobe
    st_nxt.echo_s = dte_take && local_loop; // R14
    if (dte_take && local_loop) begin
      st_nxt.echo_d = st_r.dd_sync[2]; // R14
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else if (enable_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o         = st_r.rdata;
  assign dte_rx_data_o       = st_r.echo_d;
  assign dte_rx_strobe_o     = st_r.echo_s;
  assign net_tx_data_o       = fifo_out_data;
  assign net_tx_valid_o      = fifo_out_valid;
  assign tx_data_lamp_o      = st_r.txl;
  assign rx_data_lamp_o      = st_r.rxl;
  assign sync_fail_lamp_o    = st_r.syl;
  assign alarm_lamp_o        = st_r.all;
  assign fault_lamp_o        = st_r.fll;
  assign test_mode_lamp_o    = st_r.tml;
  assign power_lamp_o        = st_r.power_lamp;
  assign carrier_loss_flag_o = st_r.closs;

  AST_TX_LAMP: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R2
    enable_i && bit_strobe_i && !slot_active_i |=> !tx_data_lamp_o)
    else $error("tx lamp lit outside active slot");
  AST_TX_ONE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R1
    enable_i && bit_strobe_i && slot_active_i |=> tx_data_lamp_o == $past(line_tx_bit_i))
    else $error("tx lamp does not follow bit");
  AST_RX_LAMP: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R3
    enable_i && bit_strobe_i |=> rx_data_lamp_o == $past(line_rx_bit_i && slot_active_i))
    else $error("rx lamp does not follow bit");
  AST_SYNC: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R5
    enable_i && !st_r.ctrl[sllc_pkg::CTRL_UNFRAMED] |=> sync_fail_lamp_o == $past(sync_lost_i))
    else $error("sync lamp wrong");
  AST_UNFRAMED: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R6
    enable_i && st_r.ctrl[sllc_pkg::CTRL_UNFRAMED] |=> sync_fail_lamp_o == !$past(tx_clock_ok_i))
    else $error("unframed sync lamp wrong");
  AST_ALARM_OFF: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    enable_i && !alarm_cond |=> !alarm_lamp_o)
    else $error("alarm lamp lit without alarm");
  AST_FAULT: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R8
    enable_i && fault_cond |=> fault_lamp_o)
    else $error("fault lamp off during fault");
  AST_TEST_STEADY: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R13
    enable_i && st_r.ctrl[sllc_pkg::CTRL_PAT_SEND] |=> test_mode_lamp_o)
    else $error("test lamp not steady");
  AST_CLOSS: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
    enable_i && bit_strobe_i && line_rx_bit_i |=> !carrier_loss_flag_o)
    else $error("carrier loss not cleared by pulse");
  AST_ECHO: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R14
    enable_i && dte_take && local_loop |=> dte_rx_strobe_o && dte_rx_data_o == $past(st_r.dd_sync[2]))
    else $error("loopback echo wrong");
  AST_TX_ZERO: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R1
    enable_i && bit_strobe_i && !line_tx_bit_i |=> !tx_data_lamp_o)
    else $error("tx lamp lit for a zero");
  AST_RX_OFF: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R4
    enable_i && bit_strobe_i && !slot_active_i |=> !rx_data_lamp_o)
    else $error("rx lamp lit outside active slot");
  AST_ALARM_START: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    enable_i && alarm_cond && flash |=> alarm_lamp_o)
    else $error("alarm lamp missed first flash");
  AST_ALARM_HALF: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    enable_i && alarm_cond && st_r.tb == sllc_pkg::TB_W'(HALF_CYC) |=> alarm_lamp_o)
    else $error("alarm lamp missed half second flash");
  AST_ALARM_GAP: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    enable_i && !flash && st_r.tb < sllc_pkg::TB_W'(HALF_CYC) |=> !alarm_lamp_o)
    else $error("alarm lamp lit between flashes");
  AST_FAULT_CLEAR: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R9
    enable_i && !fault_cond && !st_r.ctrl[sllc_pkg::CTRL_ERR_INSERT] |=> !fault_lamp_o)
    else $error("fault lamp lit without fault");
  AST_ERR_BLINK: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R10
    enable_i && !fault_cond && st_r.ctrl[sllc_pkg::CTRL_ERR_INSERT]
    |=> fault_lamp_o == $past(flash))
    else $error("error insertion blink wrong");
  AST_LOCAL_FLASH: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R11
    enable_i && local_loop && !st_r.ctrl[sllc_pkg::CTRL_REMOTE_LOOP]
    && !st_r.ctrl[sllc_pkg::CTRL_PAT_SEND] && !st_r.ctrl[sllc_pkg::CTRL_LOOP_REQ]
    |=> test_mode_lamp_o == $past(flash))
    else $error("local loop test lamp wrong");
  AST_REMOTE_FLASH: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R12
    enable_i && st_r.ctrl[sllc_pkg::CTRL_REMOTE_LOOP]
    && !st_r.ctrl[sllc_pkg::CTRL_PAT_SEND] && !st_r.ctrl[sllc_pkg::CTRL_LOOP_REQ]
    |=> test_mode_lamp_o == !$past(flash))
    else $error("remote loop test lamp wrong");
  AST_LOOP_REQ: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R13
    enable_i && st_r.ctrl[sllc_pkg::CTRL_LOOP_REQ] |=> test_mode_lamp_o)
    else $error("test lamp not steady on loop request");
  AST_ECHO_ONE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R14
    enable_i && !(dte_take && local_loop) |=> !dte_rx_strobe_o)
    else $error("echo strobe without a looped bit");
  AST_NO_LINE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R14
    enable_i && local_loop && !fifo_out_valid |=> !net_tx_valid_o)
    else $error("looped data reached the line");
  AST_LEAD_LOOP: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R15
    enable_i && st_r.ll_lead && dte_take |=> dte_rx_strobe_o)
    else $error("local loop lead ignored");
  AST_CLOSS_SET: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
    enable_i && bit_strobe_i && !line_rx_bit_i
    && st_r.zero_cnt == 8'(sllc_pkg::CLOSS_ZEROS - 1) |=> carrier_loss_flag_o)
    else $error("carrier loss not raised");
  AST_CLOSS_EARLY: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
    enable_i && !carrier_loss_flag_o && st_r.zero_cnt < 8'(sllc_pkg::CLOSS_ZEROS - 1)
    |=> !carrier_loss_flag_o)
    else $error("carrier loss raised early");
  AST_FREEZE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !enable_i |=> $stable(alarm_lamp_o) && $stable(sync_fail_lamp_o) && $stable(st_r))
    else $error("state moved while disabled");
  AST_POWER: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    enable_i |=> power_lamp_o)
    else $error("power lamp off while running");
  AST_RDATA_IDLE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    enable_i && !reg_read_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule

// small valid/ready queue; the head is registered so line outputs leave flops
module sllc_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             enable_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
  } sllc_fifo_s;
  sllc_fifo_s st_r;
  sllc_fifo_s st_nxt;
  logic push;
  logic pop;

  assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = st_r.ov;
  assign out_data_o  = st_r.od;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    // head copies kept in flops; they always match cnt and mem[rp]
    st_nxt.ov = (st_nxt.cnt != '0);
    st_nxt.od = st_nxt.mem[st_nxt.rp];
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else if (enable_i) begin
      st_r <= st_nxt;
    end
  end

  AST_FIFO_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    enable_i && out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("fifo head changed while stalled");
endmodule

// ---- sllc_far_model.sv ----
/*
  sllc_far_model: DTE and line side partner of the lamp and loop block.
  assumes the block's clock; bits are spaced well beyond the sync delay.
*/
`timescale 1ns/1ps
module sllc_far_model (
  input  wire logic clock_i,
  input  wire logic dte_rx_data_i,
  input  wire logic dte_rx_strobe_i,
  input  wire logic net_tx_data_i,
  input  wire logic net_tx_valid_i,
  output logic      dte_data_o,
  output logic      dte_strobe_o,
  output logic      dte_loop_o,
  output logic      net_ready_o
);
  logic echo_q[$];
  logic line_q[$];
  initial begin
    dte_data_o = 1'b0;
    dte_strobe_o = 1'b0;
    dte_loop_o = 1'b0;
    net_ready_o = 1'b0;
  end
  task automatic set_loop(input logic v);
    @(posedge clock_i);
    dte_loop_o <= v;
  endtask
  // line side may stall for as long as the bench likes
  task automatic set_ready(input logic v);
    @(posedge clock_i);
    net_ready_o <= v;
  endtask
  task automatic send(input logic b);
    @(posedge clock_i);
    dte_data_o <= b;
    dte_strobe_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    dte_strobe_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    // released data shows the inverse, never a stale copy
    dte_data_o <= ~b;
  endtask
  always @(posedge clock_i) begin
    if (dte_rx_strobe_i) echo_q.push_back(dte_rx_data_i);
    if (net_tx_valid_i && net_ready_o) line_q.push_back(net_tx_data_i);
  end
endmodule

// ---- sllc_top_tb_top.sv ----
/*
  sllc_top_tb_top: self-checking bench for the lamp and local loop block.
  assumes sllc_far_model plays DTE and line; timebase cut to 80 cycles.
*/
`timescale 1ns/1ps
module sllc_top_tb_top;
  localparam int SEC = 80;
  logic       clock   = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr_s    = 1'b0;
  logic       rd_s    = 1'b0;
  logic       txb     = 1'b0;
  logic       rxb     = 1'b0;
  logic       bstb    = 1'b0;
  logic       slot    = 1'b0;
  logic       clk_ok  = 1'b1;
  logic       en      = 1'b1;
  logic [3:0] alm_v   = 4'h0;
  logic [4:0] err_v   = 5'h00;
  logic [7:0] d;
  int         fail_count = 0;
  int         compares   = 0;
  wire logic [7:0] rdata;
  wire logic [7:0] lamps;
  wire logic dte_d, dte_s, dte_ll, n_rdy, rx_d, rx_s, n_d, n_v;

  always #50 clock = ~clock;

  sllc_top #(.SEC_CYC(SEC), .HALF_CYC(40), .FLASH_CYC(10)) i_dut (
    .clock_i(clock), .reset_n_i(reset_n), .enable_i(en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .line_tx_bit_i(txb), .line_rx_bit_i(rxb),
    .bit_strobe_i(bstb), .slot_active_i(slot), .sync_lost_i(alm_v[0]),
    .tx_clock_ok_i(clk_ok), .ais_i(alm_v[3]), .rai_i(alm_v[2]), .oof_i(alm_v[1]),
    .frame_err_i(err_v[4]), .excess_zero_i(err_v[3]), .slip_i(err_v[2]),
    .severe_err_i(err_v[1]), .pattern_err_i(err_v[0]), .dte_local_loop_i(dte_ll),
    .dte_data_i(dte_d), .dte_bit_strobe_i(dte_s), .net_tx_ready_i(n_rdy),
    .dte_rx_data_o(rx_d), .dte_rx_strobe_o(rx_s), .net_tx_data_o(n_d),
    .net_tx_valid_o(n_v), .tx_data_lamp_o(lamps[0]), .rx_data_lamp_o(lamps[1]),
    .sync_fail_lamp_o(lamps[2]), .alarm_lamp_o(lamps[3]), .fault_lamp_o(lamps[4]),
    .test_mode_lamp_o(lamps[5]), .power_lamp_o(lamps[6]),
    .carrier_loss_flag_o(lamps[7])
  );

  sllc_far_model i_far (
    .clock_i(clock), .dte_rx_data_i(rx_d), .dte_rx_strobe_i(rx_s),
    .net_tx_data_i(n_d), .net_tx_valid_i(n_v), .dte_data_o(dte_d),
    .dte_strobe_o(dte_s), .dte_loop_o(dte_ll), .net_ready_o(n_rdy)
  );

  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask

  task automatic pulse(input logic s, input logic t, input logic r);
    @(posedge clock);
    slot <= s;
    txb <= t;
    rxb <= r;
    bstb <= 1'b1;
    @(posedge clock);
    bstb <= 1'b0;
    @(negedge clock);
    @(negedge clock);
  endtask

  // a whole timebase period is counted, so the phase does not matter
  task automatic blink(input logic [7:0] c, input logic [3:0] a, input logic [4:0] e,
                       input int k, input int n);
    int cnt;
    wr(sllc_pkg::ADDR_CTRL, c);
    @(posedge clock);
    alm_v <= a;
    err_v <= e;
    repeat (3) @(posedge clock);
    cnt = 0;
    repeat (SEC) begin
      @(negedge clock);
      cnt += int'(lamps[k]);
    end
    check(8'(cnt), 8'(n));
  endtask

  // a frozen block ignores inputs and bus, then resumes where it stopped
  task automatic freeze();
    @(posedge clock);
    en <= 1'b0;
    alm_v <= 4'h1;
    repeat (4) @(posedge clock);
    wr(sllc_pkg::ADDR_CTRL, 8'h10);
    repeat (SEC) @(posedge clock);
    @(negedge clock);
    check(lamps, 8'h42);
    @(posedge clock);
    en <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(8'(lamps[2]), 8'h01);
    rd(sllc_pkg::ADDR_CTRL, d);
    check(d, 8'h00);
    @(posedge clock);
    alm_v <= 4'h0;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(negedge clock);
    check(lamps, 8'h40);
    rd(sllc_pkg::ADDR_CTRL, d);
    check(d, sllc_pkg::CTRL_RESET);
    rd(sllc_pkg::ADDR_STATUS, d);
    check(d, 8'h40);
    wr(sllc_pkg::ADDR_CTRL, 8'h2A);
    wr(8'h08, 8'hFF);
    rd(8'h08, d);
    check(d, 8'h00);
    rd(sllc_pkg::ADDR_CTRL, d);
    check(d, 8'h2A);
    for (int i = 0; i < 4; i++) begin
      pulse(i != 3, i != 1, i == 1);
      check(8'(lamps[0]), 8'(i == 0 || i == 2));
      check(8'(lamps[1]), 8'(i == 1));
    end
    repeat (252) pulse(1'b1, 1'b0, 1'b0);
    check(8'(lamps[7]), 8'h00);
    pulse(1'b1, 1'b0, 1'b0);
    check(8'(lamps[7]), 8'h01);
    pulse(1'b1, 1'b0, 1'b1);
    check(8'(lamps[7]), 8'h00);
    blink(8'h00, 4'h1, 5'h00, 2, 80);
    blink(8'h02, 4'h1, 5'h00, 2, 0);
    @(posedge clock);
    clk_ok <= 1'b0;
    blink(8'h02, 4'h0, 5'h00, 2, 80);
    @(posedge clock);
    clk_ok <= 1'b1;
    blink(8'h00, 4'h0, 5'h00, 2, 0);
    for (int i = 0; i < 4; i++) blink(8'h00, 4'(1 << i), 5'h00, 3, 20);
    blink(8'h00, 4'h0, 5'h00, 3, 0);
    for (int i = 0; i < 5; i++) blink(8'(i == 0) << 3, 4'h0, 5'(1 << i), 4, 80);
    blink(8'h08, 4'h0, 5'h01, 4, 80);
    blink(8'h08, 4'h0, 5'h00, 4, 0);
    blink(8'h04, 4'h0, 5'h00, 4, 10);
    blink(8'h04, 4'h0, 5'h10, 4, 80);
    blink(8'h01, 4'h0, 5'h00, 5, 10);
    blink(8'h10, 4'h0, 5'h00, 5, 70);
    blink(8'h08, 4'h0, 5'h00, 5, 80);
    blink(8'h20, 4'h0, 5'h00, 5, 80);
    blink(8'h01, 4'h0, 5'h00, 5, 10);
    for (int i = 5; i >= 0; i--) begin
      if (i == 2) begin
        i_far.set_loop(1'b1);
        repeat (8) @(posedge clock);
        wr(sllc_pkg::ADDR_CTRL, 8'h00);
        rd(sllc_pkg::ADDR_STATUS, d);
        check(8'(d[5]), 8'h01);
      end
      i_far.send(1'(6'b101101 >> i));
    end
    repeat (8) @(posedge clock);
    check(8'(i_far.echo_q.size()), 8'h06);
    for (int i = 0; i < 6; i++) check(8'(i_far.echo_q[i]), 8'(1'(6'b101101 >> (5 - i))));
    check(8'(i_far.line_q.size()), 8'h00);
    i_far.set_loop(1'b0);
    repeat (8) @(posedge clock);
    for (int i = 4; i >= 0; i--) i_far.send(1'(5'b10110 >> i));
    rd(sllc_pkg::ADDR_STATUS, d);
    check(8'(d[6]), 8'h00);
    i_far.set_ready(1'b1);
    repeat (10) @(posedge clock);
    check(8'(i_far.line_q.size()), 8'h04);
    for (int i = 0; i < 4; i++) check(8'(i_far.line_q[i]), 8'(1'(4'b1011 >> (3 - i))));
    rd(sllc_pkg::ADDR_STATUS, d);
    check(8'(d[6]), 8'h01);
    freeze();
    finish_test();
  end
endmodule
